// ---- common/aeg_regs.svh ----
// Register offsets, field positions, reset values and step limits
`ifndef AEG_REGS_SVH
`define AEG_REGS_SVH
// Register offsets
`define AEG_GAIN_OFS 8'h00
`define AEG_METHOD_OFS 8'h0e
`define AEG_EXP_LO_OFS 8'h10
`define AEG_CTRL_OFS 8'h13
`define AEG_EXP_HI_OFS 8'h16
`define AEG_SUB_LO_OFS 8'h1f
`define AEG_HI_TH_OFS 8'h24
`define AEG_LO_TH_OFS 8'h25
`define AEG_FAST_TH_OFS 8'h26
`define AEG_LUMINANCE_AVERAGE_OFS 8'h2f
`define AEG_SUB_HI_OFS 8'h3c
`define AEG_WT0_OFS 8'h4e
`define AEG_WT1_OFS 8'h4f
`define AEG_WT2_OFS 8'h50
`define AEG_WT3_OFS 8'h51
`define AEG_DARK_OFS 8'h72
`define AEG_BRIGHT_OFS 8'h73
`define AEG_VDARK_OFS 8'h74
`define AEG_VBRIGHT_OFS 8'h75
`define AEG_DARK_TR_OFS 8'h76
`define AEG_BRIGHT_TR_OFS 8'h77
`define AEG_VDARK_TR_OFS 8'h78
`define AEG_VBRIGHT_TR_OFS 8'h79
`define AEG_WIN_HS_OFS 8'h80
`define AEG_WIN_VS_OFS 8'h81
`define AEG_WIN_W_OFS 8'h82
`define AEG_WIN_H_OFS 8'h83
// Field positions
`define AEG_EXP_AUTO_BIT 0
`define AEG_GAIN_AUTO_BIT 2
`define AEG_FAST_BIT 7
`define AEG_METHOD_BIT 0
// Reset values
`define AEG_CTRL_RST 8'h05
`define AEG_EXP_RST 16'h0100
`define AEG_HI_TH_RST 8'h78
`define AEG_LO_TH_RST 8'h68
`define AEG_FAST_TH_RST 8'hd4
`define AEG_WT_RST 8'h55
`define AEG_WIN_W_RST 8'h50
`define AEG_WIN_H_RST 8'h32
// Step limits and default exposure ceiling in rows
`define AEG_STEP_MAX 16'h0020
`define AEG_FAST_MIN 16'h0002
`define AEG_STEP_ONE 16'h0001
`define AEG_EXP_MAX_DEF 16'h0320
`endif

// ---- common/aeg_pkg.sv ----
// Types shared by the exposure and gain controller
package aeg_pkg;
	typedef enum logic [2:0] {
		AEG_ST_ACC = 3'b001,
		AEG_ST_DIV = 3'b010,
		AEG_ST_DECIDE = 3'b100
	} aeg_state_t;
	typedef struct packed {
		logic wr;
		logic [7:0] addr;
		logic [7:0] wdata;
	} aeg_reg_req_t;
	typedef struct packed {
		logic valid;
		logic [1:0] chan;
		logic [11:0] x;
		logic [11:0] y;
		logic [7:0] luma;
	} aeg_pix_t;
	typedef struct packed {
		logic [7:0] gain, method, exp_lo, ctrl, exp_hi, sub_lo;
		logic [7:0] hi_th, lo_th, fast_th, luminance_average, sub_hi;
		logic [3:0][7:0] wt;
		logic [7:0] dark, bright, vdark, vbright;
		logic [7:0] dark_tr, bright_tr, vdark_tr, vbright_tr;
		logic [7:0] win_hs, win_vs, win_w, win_h;
	} aeg_cfg_t;
	typedef struct packed {
		aeg_cfg_t cfg;
		logic [3:0][31:0] wsum;
		logic [3:0][31:0] wcnt;
		logic [31:0] n_dark, n_bright, n_vdark, n_vbright, n_total;
		aeg_state_t fsm;
		logic [1:0] ch;
		logic [2:0] bitp;
		logic [7:0] q;
		logic [9:0] msum;
		logic [7:0] rdata;
		logic upd;
	} aeg_st_t;
endpackage : aeg_pkg

// ---- src/aeg_ctrl.sv ----
// Auto exposure and gain controller: statistics, decision, register file
//
// Overview of operation
// - Control bits pick auto or manual exposure, gain
// - Method bit picks weighted average or histogram
// - Exposure is high byte joined to low byte
// - Sub-row exposure joins its two byte registers
// - Gain top bit digital flag, low seven analog
// - Each frame decide rise, fall, hold; apply next
// - Average inside threshold band leaves exposure alone
// - Average above high threshold lowers exposure
// - Average below low threshold raises exposure
// - Speed bit zero gives single steps, one fast
// - Fast range nibbles times sixteen give zone bounds
// - Step twice exposure outside zone, eighth inside
// - One step never exceeds thirty-two rows
// - Hardware average is quarter of channel means sum
// - Four by four zones weighted into average
// - Window start, width, height set the grid
// - Zone weights packed ascending, two bits each
// - Histogram mode reuses thresholds as luminance band
// - Dark at or below, bright at or above limits
// - Dark share over trigger raises, bright lowers
// - Very dark, very bright shares force fast steps
`timescale 1ns/1ns
`include "aeg_regs.svh"
module aeg_ctrl
	import aeg_pkg::*;
#(
	parameter logic [15:0] EXP_MAX = `AEG_EXP_MAX_DEF
)
(
	input wire logic SYS_CLK_I,
	input wire logic RST_N_I,
	input wire aeg_reg_req_t REG_REQ_I,
	output logic [7:0] REG_RDATA_O,
	input wire aeg_pix_t PIX_I,
	input wire logic FRAME_START_I,
	input wire logic FRAME_END_I,
	output logic [15:0] EXPOSURE_O,
	output logic [15:0] SUBROW_EXPOSURE_O,
	output logic [7:0] GAIN_O,
	output logic UPDATE_O
);
	aeg_st_t st_r, st_nxt;
	logic [1:0] zone_wt [16];
	logic [11:0] h_start, v_start, rx, ry;
	logic [10:0] zw1, zw2, zw3, zw4, zh1, zh2, zh3, zh4;
	logic in_win;
	logic [1:0] col, row;
	logic [1:0] pix_wt;
	logic [7:0] trial;
	logic fits;
	logic [15:0] exp_cur, raw_step, step, exp_up, exp_dn;
	logic [16:0] twice;
	logic [7:0] y_new, fz_hi, fz_lo;
	logic auto_exp, auto_gain, fast_sel, hist_mode, in_band;
	logic dk_over, br_over, vdk_over, vbr_over, go_up, go_down, far;

	// Share test without a divider: count/total > trig/256
	function automatic logic share_over(input logic [31:0] cnt,
		input logic [7:0] trig, input logic [31:0] total);
		share_over = {cnt, 8'h00} > (40'(trig) * 40'(total));
	endfunction : share_over

	// Unpack the sixteen two-bit zone weights, zone 1 lowest
	generate
		for (genvar i = 0; i < 16; i++)
		begin : g_wt
			assign zone_wt[i] = st_r.cfg.wt[i / 4][(i % 4) * 2 +: 2];
		end
	endgenerate

	// Window grid: start in 8-pixel units, zone size twice the register
	assign h_start = {1'b0, st_r.cfg.win_hs, 3'h0};
	assign v_start = {1'b0, st_r.cfg.win_vs, 3'h0};
	assign rx = PIX_I.x - h_start;
	assign ry = PIX_I.y - v_start;
	assign zw1 = {2'h0, st_r.cfg.win_w, 1'b0};
	assign zw2 = {1'b0, st_r.cfg.win_w, 2'h0};
	assign zw3 = zw1 + zw2;
	assign zw4 = {st_r.cfg.win_w, 3'h0};
	assign zh1 = {2'h0, st_r.cfg.win_h, 1'b0};
	assign zh2 = {1'b0, st_r.cfg.win_h, 2'h0};
	assign zh3 = zh1 + zh2;
	assign zh4 = {st_r.cfg.win_h, 3'h0};
	// Comparisons instead of division keep the zone lookup one cycle
	assign in_win = (PIX_I.x >= h_start) && (rx < {1'b0, zw4}) &&
		(PIX_I.y >= v_start) && (ry < {1'b0, zh4});
	assign col = 2'(rx >= {1'b0, zw1}) + 2'(rx >= {1'b0, zw2}) +
		2'(rx >= {1'b0, zw3});
	assign row = 2'(ry >= {1'b0, zh1}) + 2'(ry >= {1'b0, zh2}) +
		2'(ry >= {1'b0, zh3});
	assign pix_wt = zone_wt[{row, col}];

	// Mean per channel by an eight-step binary search on the quotient
	assign trial = st_r.q | (8'h01 << st_r.bitp);
	assign fits = (st_r.wcnt[st_r.ch] != 32'h0) &&
		((40'(trial) * 40'(st_r.wcnt[st_r.ch])) <=
		{8'h00, st_r.wsum[st_r.ch]});

	// Decision inputs
	assign exp_cur = {st_r.cfg.exp_hi, st_r.cfg.exp_lo};
	assign y_new = 8'(st_r.msum >> 2);
	assign auto_exp = st_r.cfg.ctrl[`AEG_EXP_AUTO_BIT];
	assign auto_gain = st_r.cfg.ctrl[`AEG_GAIN_AUTO_BIT];
	assign fast_sel = st_r.cfg.ctrl[`AEG_FAST_BIT];
	assign hist_mode = st_r.cfg.method[`AEG_METHOD_BIT];
	assign fz_hi = {st_r.cfg.fast_th[7:4], 4'h0};
	assign fz_lo = {st_r.cfg.fast_th[3:0], 4'h0};
	assign in_band = (y_new >= st_r.cfg.lo_th) && (y_new <= st_r.cfg.hi_th);
	assign dk_over = share_over(st_r.n_dark, st_r.cfg.dark_tr,
		st_r.n_total);
	assign br_over = share_over(st_r.n_bright, st_r.cfg.bright_tr,
		st_r.n_total);
	assign vdk_over = share_over(st_r.n_vdark, st_r.cfg.vdark_tr,
		st_r.n_total);
	assign vbr_over = share_over(st_r.n_vbright, st_r.cfg.vbright_tr,
		st_r.n_total);
	// Histogram mode holds while the average sits in the band
	always_comb
	begin
		if (hist_mode)
		begin
			go_up = !in_band && (dk_over || vdk_over) &&
				!(br_over || vbr_over);
			go_down = !in_band && (br_over || vbr_over) &&
				!(dk_over || vdk_over);
			far = fast_sel && (vdk_over || vbr_over);
		end
		else
		begin
			go_up = y_new < st_r.cfg.lo_th;
			go_down = y_new > st_r.cfg.hi_th;
			far = fast_sel && ((y_new > fz_hi) || (y_new < fz_lo));
		end
	end

	// Step size: single step, or fast step sized from exposure
	assign twice = {exp_cur, 1'b0};
	assign raw_step = far ? ((twice > 17'(`AEG_STEP_MAX)) ? `AEG_STEP_MAX :
		twice[15:0]) : {3'h0, exp_cur[15:3]};
	always_comb
	begin
		if (!fast_sel)
			step = `AEG_STEP_ONE;
		else if (raw_step > `AEG_STEP_MAX)
			step = `AEG_STEP_MAX;
		else if (raw_step < `AEG_FAST_MIN)
			step = `AEG_FAST_MIN;
		else
			step = raw_step;
	end
	// Saturating moves keep exposure within one row and the ceiling
	assign exp_up = ((EXP_MAX - exp_cur) < step) ? EXP_MAX : exp_cur + step;
	assign exp_dn = (exp_cur > step) ? exp_cur - step : `AEG_STEP_ONE;

	// Next state: statistics, divider, decision, then register port
	always_comb
	begin
		st_nxt = st_r;
		st_nxt.upd = 1'b0;
		case (st_r.fsm)
			AEG_ST_ACC:
			begin
				if (FRAME_START_I)
				begin
					st_nxt.wsum = '0;
					st_nxt.wcnt = '0;
					st_nxt.n_dark = 32'h0;
					st_nxt.n_bright = 32'h0;
					st_nxt.n_vdark = 32'h0;
					st_nxt.n_vbright = 32'h0;
					st_nxt.n_total = 32'h0;
				end
				if (PIX_I.valid)
				begin
					if (in_win)
					begin
						st_nxt.wsum[PIX_I.chan] = st_nxt.wsum[PIX_I.chan] +
							32'(PIX_I.luma) * 32'(pix_wt);
						st_nxt.wcnt[PIX_I.chan] = st_nxt.wcnt[PIX_I.chan] +
							32'(pix_wt);
					end
					st_nxt.n_total = st_nxt.n_total + 32'h1;
					if (PIX_I.luma <= st_r.cfg.dark)
						st_nxt.n_dark = st_nxt.n_dark + 32'h1;
					if (PIX_I.luma >= st_r.cfg.bright)
						st_nxt.n_bright = st_nxt.n_bright + 32'h1;
					if (PIX_I.luma <= st_r.cfg.vdark)
						st_nxt.n_vdark = st_nxt.n_vdark + 32'h1;
					if (PIX_I.luma >= st_r.cfg.vbright)
						st_nxt.n_vbright = st_nxt.n_vbright + 32'h1;
				end
				if (FRAME_END_I)
				begin
					st_nxt.fsm = AEG_ST_DIV;
					st_nxt.ch = 2'h0;
					st_nxt.bitp = 3'h7;
					st_nxt.q = 8'h0;
					st_nxt.msum = 10'h0;
				end
			end
			AEG_ST_DIV:
			begin
				st_nxt.q = fits ? trial : st_r.q;
				st_nxt.bitp = st_r.bitp - 3'h1;
				if (st_r.bitp == 3'h0)
				begin
					// Sum of the four channel means, quartered at decision
					st_nxt.msum = st_r.msum + 10'(st_nxt.q);
					st_nxt.q = 8'h0;
					st_nxt.ch = st_r.ch + 2'h1;
					if (st_r.ch == 2'h3)
						st_nxt.fsm = AEG_ST_DECIDE;
				end
			end
			AEG_ST_DECIDE:
			begin
				st_nxt.cfg.luminance_average = y_new;
				st_nxt.upd = 1'b1;
				st_nxt.fsm = AEG_ST_ACC;
				// Brighter: exposure first for noise, then gain
				if (go_up)
				begin
					if (auto_exp && (exp_cur < EXP_MAX))
						{st_nxt.cfg.exp_hi, st_nxt.cfg.exp_lo} = exp_up;
					else if (auto_gain && (st_r.cfg.gain[6:0] != 7'h7f))
						st_nxt.cfg.gain[6:0] = st_r.cfg.gain[6:0] + 7'h1;
				end
				// Darker: gain comes down before exposure shortens
				else if (go_down)
				begin
					if (auto_gain && (st_r.cfg.gain[6:0] != 7'h00))
						st_nxt.cfg.gain[6:0] = st_r.cfg.gain[6:0] - 7'h1;
					else if (auto_exp && (exp_cur > `AEG_STEP_ONE))
						{st_nxt.cfg.exp_hi, st_nxt.cfg.exp_lo} = exp_dn;
				end
			end
			default:
			begin
				st_nxt.fsm = AEG_ST_ACC;
			end
		endcase
		// Read data follows the address one cycle later
		case (REG_REQ_I.addr)
			`AEG_GAIN_OFS: st_nxt.rdata = st_r.cfg.gain;
			`AEG_METHOD_OFS: st_nxt.rdata = st_r.cfg.method;
			`AEG_EXP_LO_OFS: st_nxt.rdata = st_r.cfg.exp_lo;
			`AEG_CTRL_OFS: st_nxt.rdata = st_r.cfg.ctrl;
			`AEG_EXP_HI_OFS: st_nxt.rdata = st_r.cfg.exp_hi;
			`AEG_SUB_LO_OFS: st_nxt.rdata = st_r.cfg.sub_lo;
			`AEG_HI_TH_OFS: st_nxt.rdata = st_r.cfg.hi_th;
			`AEG_LO_TH_OFS: st_nxt.rdata = st_r.cfg.lo_th;
			`AEG_FAST_TH_OFS: st_nxt.rdata = st_r.cfg.fast_th;
			`AEG_LUMINANCE_AVERAGE_OFS: st_nxt.rdata = st_r.cfg.luminance_average;
			`AEG_SUB_HI_OFS: st_nxt.rdata = st_r.cfg.sub_hi;
			`AEG_WT0_OFS: st_nxt.rdata = st_r.cfg.wt[0];
			`AEG_WT1_OFS: st_nxt.rdata = st_r.cfg.wt[1];
			`AEG_WT2_OFS: st_nxt.rdata = st_r.cfg.wt[2];
			`AEG_WT3_OFS: st_nxt.rdata = st_r.cfg.wt[3];
			`AEG_DARK_OFS: st_nxt.rdata = st_r.cfg.dark;
			`AEG_BRIGHT_OFS: st_nxt.rdata = st_r.cfg.bright;
			`AEG_VDARK_OFS: st_nxt.rdata = st_r.cfg.vdark;
			`AEG_VBRIGHT_OFS: st_nxt.rdata = st_r.cfg.vbright;
			`AEG_DARK_TR_OFS: st_nxt.rdata = st_r.cfg.dark_tr;
			`AEG_BRIGHT_TR_OFS: st_nxt.rdata = st_r.cfg.bright_tr;
			`AEG_VDARK_TR_OFS: st_nxt.rdata = st_r.cfg.vdark_tr;
			`AEG_VBRIGHT_TR_OFS: st_nxt.rdata = st_r.cfg.vbright_tr;
			`AEG_WIN_HS_OFS: st_nxt.rdata = st_r.cfg.win_hs;
			`AEG_WIN_VS_OFS: st_nxt.rdata = st_r.cfg.win_vs;
			`AEG_WIN_W_OFS: st_nxt.rdata = st_r.cfg.win_w;
			`AEG_WIN_H_OFS: st_nxt.rdata = st_r.cfg.win_h;
			default: st_nxt.rdata = 8'h00;
		endcase
		// Software writes come last so they beat a same-cycle update
		if (REG_REQ_I.wr)
		begin
			case (REG_REQ_I.addr)
				`AEG_GAIN_OFS: st_nxt.cfg.gain = REG_REQ_I.wdata;
				`AEG_METHOD_OFS: st_nxt.cfg.method = REG_REQ_I.wdata;
				`AEG_EXP_LO_OFS: st_nxt.cfg.exp_lo = REG_REQ_I.wdata;
				`AEG_CTRL_OFS: st_nxt.cfg.ctrl = REG_REQ_I.wdata;
				`AEG_EXP_HI_OFS: st_nxt.cfg.exp_hi = REG_REQ_I.wdata;
				`AEG_SUB_LO_OFS: st_nxt.cfg.sub_lo = REG_REQ_I.wdata;
				`AEG_HI_TH_OFS: st_nxt.cfg.hi_th = REG_REQ_I.wdata;
				`AEG_LO_TH_OFS: st_nxt.cfg.lo_th = REG_REQ_I.wdata;
				`AEG_FAST_TH_OFS: st_nxt.cfg.fast_th = REG_REQ_I.wdata;
				`AEG_SUB_HI_OFS: st_nxt.cfg.sub_hi = REG_REQ_I.wdata;
				`AEG_WT0_OFS: st_nxt.cfg.wt[0] = REG_REQ_I.wdata;
				`AEG_WT1_OFS: st_nxt.cfg.wt[1] = REG_REQ_I.wdata;
				`AEG_WT2_OFS: st_nxt.cfg.wt[2] = REG_REQ_I.wdata;
				`AEG_WT3_OFS: st_nxt.cfg.wt[3] = REG_REQ_I.wdata;
				`AEG_DARK_OFS: st_nxt.cfg.dark = REG_REQ_I.wdata;
				`AEG_BRIGHT_OFS: st_nxt.cfg.bright = REG_REQ_I.wdata;
				`AEG_VDARK_OFS: st_nxt.cfg.vdark = REG_REQ_I.wdata;
				`AEG_VBRIGHT_OFS: st_nxt.cfg.vbright = REG_REQ_I.wdata;
				`AEG_DARK_TR_OFS: st_nxt.cfg.dark_tr = REG_REQ_I.wdata;
				`AEG_BRIGHT_TR_OFS: st_nxt.cfg.bright_tr = REG_REQ_I.wdata;
				`AEG_VDARK_TR_OFS: st_nxt.cfg.vdark_tr = REG_REQ_I.wdata;
				`AEG_VBRIGHT_TR_OFS: st_nxt.cfg.vbright_tr = REG_REQ_I.wdata;
				`AEG_WIN_HS_OFS: st_nxt.cfg.win_hs = REG_REQ_I.wdata;
				`AEG_WIN_VS_OFS: st_nxt.cfg.win_vs = REG_REQ_I.wdata;
				`AEG_WIN_W_OFS: st_nxt.cfg.win_w = REG_REQ_I.wdata;
				`AEG_WIN_H_OFS: st_nxt.cfg.win_h = REG_REQ_I.wdata;
				default: st_nxt.cfg = st_nxt.cfg;
			endcase
		end
	end

	// State register with synchronous reset
	always_ff @(posedge SYS_CLK_I)
	begin
		if (!RST_N_I)
		begin
			st_r <= '0;
			st_r.fsm <= AEG_ST_ACC;
			st_r.bitp <= 3'h7;
			st_r.cfg.ctrl <= `AEG_CTRL_RST;
			st_r.cfg.exp_hi <= 8'(`AEG_EXP_RST >> 8);
			st_r.cfg.exp_lo <= 8'(`AEG_EXP_RST);
			st_r.cfg.hi_th <= `AEG_HI_TH_RST;
			st_r.cfg.lo_th <= `AEG_LO_TH_RST;
			st_r.cfg.fast_th <= `AEG_FAST_TH_RST;
			st_r.cfg.wt <= {4{`AEG_WT_RST}};
			st_r.cfg.win_w <= `AEG_WIN_W_RST;
			st_r.cfg.win_h <= `AEG_WIN_H_RST;
			st_r.cfg.bright <= 8'hff;
			st_r.cfg.vbright <= 8'hff;
		end
		else
			st_r <= st_nxt;
	end

	// Outputs straight from the state register
	assign REG_RDATA_O = st_r.rdata;
	assign EXPOSURE_O = {st_r.cfg.exp_hi, st_r.cfg.exp_lo};
	assign SUBROW_EXPOSURE_O = {st_r.cfg.sub_hi, st_r.cfg.sub_lo};
	assign GAIN_O = st_r.cfg.gain;
	assign UPDATE_O = st_r.upd;

	// Checks
	logic wr_exp, wr_gain, dec;
	assign wr_exp = REG_REQ_I.wr && ((REG_REQ_I.addr == `AEG_EXP_HI_OFS) ||
		(REG_REQ_I.addr == `AEG_EXP_LO_OFS));
	assign wr_gain = REG_REQ_I.wr && (REG_REQ_I.addr == `AEG_GAIN_OFS);
	assign dec = st_r.fsm == AEG_ST_DECIDE;
	default clocking cb @(posedge SYS_CLK_I); endclocking
	default disable iff (!RST_N_I);
	sequence s_frame_end;
		(st_r.fsm == AEG_ST_ACC) && FRAME_END_I;
	endsequence
	sequence s_decide_clean;
		dec && !wr_exp && !hist_mode;
	endsequence
	chk_manual_exp_hold: assert property (!auto_exp && !wr_exp |=>
		$stable(EXPOSURE_O)) else $error("manual exposure changed");
	chk_manual_gain_hold: assert property (!auto_gain && !wr_gain |=>
		$stable(GAIN_O)) else $error("manual gain changed");
	chk_exp_high_byte: assert property (REG_REQ_I.wr &&
		REG_REQ_I.addr == `AEG_EXP_HI_OFS |=>
		EXPOSURE_O[15:8] == $past(REG_REQ_I.wdata))
		else $error("exposure high byte not stored");
	chk_subrow_low_byte: assert property (REG_REQ_I.wr &&
		REG_REQ_I.addr == `AEG_SUB_LO_OFS |=>
		SUBROW_EXPOSURE_O[7:0] == $past(REG_REQ_I.wdata))
		else $error("sub-row low byte not stored");
	chk_frame_update: assert property (s_frame_end |=>
		!UPDATE_O [*8] ##26 UPDATE_O) else $error("update timing wrong");
	chk_avg_hold: assert property (s_decide_clean and in_band |=>
		$stable(EXPOSURE_O)) else $error("exposure moved inside band");
	chk_avg_down: assert property (s_decide_clean and
		(y_new > st_r.cfg.hi_th) && (y_new >= st_r.cfg.lo_th) && auto_exp &&
		(!auto_gain || st_r.cfg.gain[6:0] == 7'h00) && exp_cur > 16'h0001
		|=> EXPOSURE_O < $past(EXPOSURE_O))
		else $error("exposure not lowered");
	chk_avg_up: assert property (s_decide_clean and
		(y_new < st_r.cfg.lo_th) && auto_exp && exp_cur < EXP_MAX
		|=> EXPOSURE_O > $past(EXPOSURE_O)) else $error("exposure not raised");
	chk_normal_step: assert property (dec && !fast_sel && !wr_exp |=>
		16'(EXPOSURE_O - $past(EXPOSURE_O)) <= `AEG_STEP_ONE ||
		16'($past(EXPOSURE_O) - EXPOSURE_O) <= `AEG_STEP_ONE)
		else $error("normal step above one");
	chk_step_limit: assert property (dec && !wr_exp |=>
		16'(EXPOSURE_O - $past(EXPOSURE_O)) <= `AEG_STEP_MAX ||
		16'($past(EXPOSURE_O) - EXPOSURE_O) <= `AEG_STEP_MAX)
		else $error("step above limit");
	chk_avg_read_only: assert property (!dec |=>
		$stable(st_r.cfg.luminance_average)) else $error("average changed off decision");
endmodule : aeg_ctrl

// ---- testbench/aeg_ctrl_bench.sv ----
// Self-checking bench for the exposure and gain controller
`timescale 1ns/1ns
`include "aeg_regs.svh"
module aeg_ctrl_bench
	import aeg_pkg::*;
;
	logic sys_clk;
	logic rst_n;
	aeg_reg_req_t reg_req;
	logic [7:0] reg_rdata;
	aeg_pix_t pix;
	logic frame_start;
	logic frame_end;
	logic [15:0] exposure;
	logic [15:0] subrow;
	logic [7:0] gain;
	logic update;
	int error_cnt;
	int checks;

	aeg_ctrl #(
		.EXP_MAX(16'h0320)
	) aeg_ctrl_inst (
		.SYS_CLK_I(sys_clk),
		.RST_N_I(rst_n),
		.REG_REQ_I(reg_req),
		.REG_RDATA_O(reg_rdata),
		.PIX_I(pix),
		.FRAME_START_I(frame_start),
		.FRAME_END_I(frame_end),
		.EXPOSURE_O(exposure),
		.SUBROW_EXPOSURE_O(subrow),
		.GAIN_O(gain),
		.UPDATE_O(update)
	);

	// 25 MHz clock
	initial
	begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end

	// Verdict and end of run
	task close_out;
		$display("checks=%0d error_cnt=%0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : close_out

	// Case equality so an unknown never passes
	task chk(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	// One-cycle write strobe, launched off the falling edge
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge sys_clk);
		reg_req.wr = 1'b1;
		reg_req.addr = a;
		reg_req.wdata = d;
		@(negedge sys_clk);
		reg_req.wr = 1'b0;
	endtask : wr

	// Read data is registered: one rising edge after the address
	task rchk(input logic [7:0] a, input logic [7:0] e);
		@(negedge sys_clk);
		reg_req.addr = a;
		@(negedge sys_clk);
		chk({8'h00, reg_rdata}, {8'h00, e});
	endtask : rchk

	// Two zones of one row, every channel; then wait for the update
	task frame(input logic [7:0] la, input logic [7:0] lb);
		int n;
		@(negedge sys_clk);
		frame_start = 1'b1;
		@(negedge sys_clk);
		frame_start = 1'b0;
		for (int c = 0; c < 4; c++)
		begin
			pix = '{1'b1, c[1:0], 12'h000, 12'h000, la};
			@(negedge sys_clk);
			pix = '{1'b1, c[1:0], 12'h0a0, 12'h000, lb};
			@(negedge sys_clk);
		end
		pix.valid = 1'b0;
		frame_end = 1'b1;
		@(negedge sys_clk);
		frame_end = 1'b0;
		n = 0;
		while (n < 40 && update !== 1'b1)
		begin
			@(posedge sys_clk);
			#1;
			n++;
		end
		if (n >= 40)
		begin
			error_cnt++;
			$display("[FAIL] t=%0t update missing got=%h exp=%h", $time,
				n, 33);
			close_out();
		end
		else
		begin
			// Pulse shows after the 33rd edge past the end-of-frame edge
			chk(n[15:0], 16'h0021);
			@(negedge sys_clk);
			chk({15'h0000, update}, 16'h0001);
			@(negedge sys_clk);
			chk({15'h0000, update}, 16'h0000);
		end
	endtask : frame

	// Program control and exposure, run a flat frame, check result
	task step(input logic [7:0] ctl, input logic [15:0] e0,
		input logic [7:0] luma, input logic [15:0] e1);
		wr(`AEG_CTRL_OFS, ctl);
		wr(`AEG_EXP_HI_OFS, e0[15:8]);
		wr(`AEG_EXP_LO_OFS, e0[7:0]);
		frame(luma, luma);
		chk(exposure, e1);
		rchk(`AEG_LUMINANCE_AVERAGE_OFS, luma);
	endtask : step

	// Watchdog against a hang anywhere in the sequence
	initial
	begin
		#2000000;
		error_cnt++;
		$display("[FAIL] t=%0t watchdog got=%h exp=%h", $time, 1, 0);
		close_out();
	end

	// Main sequence
	initial
	begin
		error_cnt = 0;
		checks = 0;
		rst_n = 1'b0;
		reg_req = '0;
		pix = '0;
		frame_start = 1'b0;
		frame_end = 1'b0;
		repeat (12) @(posedge sys_clk);
		@(negedge sys_clk);
		rst_n = 1'b1;

		// Reset values and plain storage
		rchk(`AEG_CTRL_OFS, `AEG_CTRL_RST);
		rchk(`AEG_METHOD_OFS, 8'h00);
		rchk(`AEG_HI_TH_OFS, `AEG_HI_TH_RST);
		rchk(`AEG_LO_TH_OFS, `AEG_LO_TH_RST);
		rchk(`AEG_FAST_TH_OFS, `AEG_FAST_TH_RST);
		rchk(`AEG_WIN_W_OFS, `AEG_WIN_W_RST);
		rchk(`AEG_WT0_OFS, `AEG_WT_RST);
		chk(exposure, `AEG_EXP_RST);
		chk({8'h00, gain}, 16'h0000);
		wr(`AEG_SUB_HI_OFS, 8'h12);
		wr(`AEG_SUB_LO_OFS, 8'h34);
		chk(subrow, 16'h1234);
		wr(`AEG_EXP_HI_OFS, 8'hab);
		wr(`AEG_EXP_LO_OFS, 8'hcd);
		chk(exposure, 16'habcd);
		rchk(`AEG_EXP_HI_OFS, 8'hab);
		wr(`AEG_LUMINANCE_AVERAGE_OFS, 8'haa);
		rchk(`AEG_LUMINANCE_AVERAGE_OFS, 8'h00);
		rchk(8'h90, 8'h00);
		$display("test registers done");

		// Average mode, single steps, band edges inclusive
		step(8'h01, 16'h0100, 8'h40, 16'h0101);
		step(8'h01, 16'h0100, 8'h68, 16'h0100);
		step(8'h01, 16'h0100, 8'h78, 16'h0100);
		step(8'h01, 16'h0100, 8'h79, 16'h00ff);
		step(8'h01, 16'h0100, 8'h67, 16'h0101);
		$display("test average normal done");

		// Fast steps: zone outside gives 2x exposure, inside 1/8, [2,32]
		step(8'h81, 16'h0008, 8'h20, 16'h0018);
		step(8'h81, 16'h0040, 8'h50, 16'h0048);
		step(8'h81, 16'h0100, 8'h20, 16'h0120);
		step(8'h81, 16'h0100, 8'he0, 16'h00e0);
		step(8'h81, 16'h0008, 8'h90, 16'h0006);
		$display("test average fast done");

		// Gain path and manual hold
		wr(`AEG_GAIN_OFS, 8'h85);
		step(8'h04, 16'h0100, 8'h40, 16'h0100);
		chk({8'h00, gain}, 16'h0086);
		step(8'h04, 16'h0100, 8'h90, 16'h0100);
		chk({8'h00, gain}, 16'h0085);
		step(8'h05, 16'h0100, 8'h90, 16'h0100);
		chk({8'h00, gain}, 16'h0084);
		step(8'h05, 16'h0100, 8'h40, 16'h0101);
		chk({8'h00, gain}, 16'h0084);
		step(8'h00, 16'h0100, 8'h40, 16'h0100);
		chk({8'h00, gain}, 16'h0084);
		rchk(`AEG_GAIN_OFS, 8'h84);
		$display("test gain and manual done");

		// Zone weights: zone 1 weight 1, zone 2 weight 3
		wr(`AEG_WT0_OFS, 8'h0d);
		frame(8'h10, 8'h50);
		rchk(`AEG_LUMINANCE_AVERAGE_OFS, 8'h40);
		wr(`AEG_WT0_OFS, 8'h55);
		$display("test zone weights done");

		// Histogram mode
		wr(`AEG_METHOD_OFS, 8'h01);
		wr(`AEG_DARK_OFS, 8'h10);
		wr(`AEG_DARK_TR_OFS, 8'h80);
		step(8'h01, 16'h0100, 8'h10, 16'h0101);
		wr(`AEG_DARK_OFS, 8'h0f);
		step(8'h01, 16'h0100, 8'h10, 16'h0100);
		wr(`AEG_BRIGHT_OFS, 8'hf0);
		wr(`AEG_BRIGHT_TR_OFS, 8'h80);
		step(8'h01, 16'h0100, 8'hf0, 16'h00ff);
		wr(`AEG_DARK_OFS, 8'h10);
		wr(`AEG_VDARK_OFS, 8'h10);
		wr(`AEG_VDARK_TR_OFS, 8'h80);
		step(8'h81, 16'h0008, 8'h10, 16'h0018);
		$display("test histogram done");
		close_out();
	end
endmodule : aeg_ctrl_bench
